// [include/iso_input_cfg.svh]
// constants for the isolated input link: offsets, fields, resets, timing counts
// assumes a 20 MHz system clock
`ifndef ISO_INPUT_CFG_SVH
`define ISO_INPUT_CFG_SVH
`define CLOCK_HZ 20000000
`define OSC_HZ 500000
`define SCAN_DIV (`CLOCK_HZ / `OSC_HZ)
`define REG_DATA 7'h00
`define REG_DIAG 7'h01
`define REG_SETUP 7'h02
`define REG_GFAULT 7'h03
`define REG_LFAULT 7'h04
`define REG_MASK 7'h05
`define REG_FILT_PAGE 4'h1
`define SETUP_HALVER_BIT 0
`define SETUP_RESET 8'h00
`define MASK_RESET 8'hFF
`define FILT_RESET 8'h03
`define GFAULT_RESET 3'h7
`define LFAULT_RESET 2'h1
`define FRAME_BITS 5'h10
`define ADDR_BITS 5'h08
`define HOST_PHASE_CYC 4'h3
`define SCLK_HALF_CYC 4'h4
`define APB_CMD 12'h000
`define APB_STATUS 12'h004
`define APB_CONFIG 12'h008
`define CONFIG_RESET 5'h09
`endif

// [include/iso_input_pkg.sv]
// types shared by both ends of the isolated input link
// no assumptions beyond the config header
package iso_input_pkg;
  typedef logic [6:0] reg_addr_t;
  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_GAP, H_STROBE, H_HOLD, H_SER} host_state_t;
endpackage

// [include/iso_link_if.sv]
// pins between the controller and the isolated input device
// open-drain pins resolve to high unless their enable is set
`timescale 1ns/1ps
`default_nettype none
interface iso_link_if;
  logic chipSelN;
  logic linkTypeSel;
  logic linkVariantB0;
  logic linkVariantB1;
  logic sampleFreeze;
  logic converterDriveEnable;
  logic addrPhase;
  logic readStrobeN;
  logic storeStrobeN;
  logic [7:0] hostBus;
  logic hostBusOe;
  logic [7:0] devBus;
  logic devBusOe;
  logic [7:0] muxedBus;
  logic shiftClock;
  logic serialInData;
  logic serialInStatus;
  logic serialOutData;
  logic serialOutDiag;
  logic faultOe;
  logic checkFaultOe;
  logic switchAOe;
  logic switchBOe;
  logic faultN;
  logic checkFaultN;
  assign muxedBus = devBusOe ? devBus : (hostBusOe ? hostBus : 8'hFF);
  assign faultN = ~faultOe;
  assign checkFaultN = ~checkFaultOe;
  modport device (input chipSelN, linkTypeSel, linkVariantB0, linkVariantB1, sampleFreeze,
    converterDriveEnable, addrPhase, readStrobeN, storeStrobeN, muxedBus, shiftClock, serialInData,
    serialInStatus, output devBus, devBusOe, serialOutData, serialOutDiag, faultOe, checkFaultOe,
    switchAOe, switchBOe);
  modport host (output chipSelN, linkTypeSel, linkVariantB0, linkVariantB1, sampleFreeze,
    converterDriveEnable, addrPhase, readStrobeN, storeStrobeN, hostBus, hostBusOe, shiftClock,
    serialInData, serialInStatus, input muxedBus, serialOutData, serialOutDiag, faultN, checkFaultN);
endinterface
`default_nettype wire

// [hdl/iso_channel_filter.sv]
// one input channel filter: output follows a stable sample run
// assumes tick is a one-cycle scan enable
`timescale 1ns/1ps
`default_nettype none
module iso_channel_filter (
  input wire logic clock, // system clock
  input wire logic rstn, // synchronous reset, low active
  input wire logic tick, // scan enable pulse
  input wire logic sample, // comparator value
  input wire logic [7:0] length, // samples needed to change
  output logic level // filtered output
);
  logic [7:0] run_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      run_r <= 8'h00;
      level <= 1'b0;
    end else if (tick) begin
      if (sample == level) begin
        run_r <= 8'h00;
      end else if (run_r + 8'h01 >= length) begin
        level <= sample;
        run_r <= 8'h00;
      end else begin
        run_r <= run_r + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [hdl/iso_input_device.sv]
// device end of the isolated input link: parallel and serial register access,
// sample freeze, channel filters, fault outputs and converter switch drive
// assumes all link inputs are synchronous to clock
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "iso_input_cfg.svh"
module iso_input_device import iso_input_pkg::*; #(
  parameter int SCAN_DIV = `SCAN_DIV
) (
  iso_link_if.device link, // link pins
  input wire logic clock, // system clock
  input wire logic rstn, // synchronous reset, low active
  input wire logic [7:0] sensorIn, // comparator levels
  input wire logic [7:0] wireOpen, // open wire detections
  input wire logic supplyLow, // sensor supply below low threshold
  input wire logic supplyLost, // sensor supply missing
  input wire logic transmitFail, // internal transfer failure
  input wire logic overcurrent, // converter overcurrent
  output logic [7:0] dataView, // frozen input data register
  output logic [7:0] diagView, // frozen diagnostic register
  output logic faultActive // fault output asserted
);
  logic [7:0] scanCnt_r;
  logic scanTick;
  logic started_r;
  logic serialMode_r;
  logic halfTick_r;
  logic swPhase_r;
  logic [7:0] setup_r;
  logic [7:0] mask_r;
  logic [7:0] filtLen_r [8];
  logic [7:0] filtOut;
  logic syncPrev_r;
  logic [2:0] gFault_r;
  logic [1:0] lFault_r;
  logic [7:0] wireFlag_r;
  logic regWrEn;
  reg_addr_t regWrAddr;
  logic [7:0] regWrData;
  logic regRdDone;
  reg_addr_t regRdAddr;
  reg_addr_t parAddr_r;
  logic parDirWr_r;
  logic rdActive_r;
  logic wrActive_r;
  logic [7:0] parRd_r;
  logic [7:0] parWr_r;
  logic parActive;
  logic [4:0] bitCnt_r;
  logic [15:0] rxShift_r;
  logic [7:0] txData_r;
  logic [7:0] txDiag_r;
  logic clkPrev_r;
  logic csPrev_r;
  logic parity_r;
  logic ssiLast_r;
  logic serActive;
  logic clkRise;
  logic clkFall;
  logic csFall;
  logic frameEnd;
  logic frameBad;
  logic checkEvt;

  function automatic logic [7:0] readReg(input reg_addr_t a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `REG_DATA: v = dataView;
      `REG_DIAG: v = diagView;
      `REG_SETUP: v = setup_r;
      `REG_GFAULT: v = {5'h00, gFault_r};
      `REG_LFAULT: v = {6'h00, lFault_r};
      `REG_MASK: v = mask_r;
      default: v = (a[6:3] == `REG_FILT_PAGE) ? filtLen_r[a[2:0]] : 8'h00;
    endcase
    return v;
  endfunction

  // oscillator scan rate
  assign scanTick = (scanCnt_r == 8'(SCAN_DIV - 1));
  always_ff @(posedge clock) begin
    if (!rstn || scanTick) begin
      scanCnt_r <= 8'h00;
    end else begin
      scanCnt_r <= scanCnt_r + 8'h01;
    end
  end

  // link type strap caught once after reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      started_r <= 1'b0;
      serialMode_r <= 1'b1;
    end else if (!started_r) begin
      started_r <= 1'b1;
      serialMode_r <= link.linkTypeSel;
    end
  end

  // converter switch drive
  always_ff @(posedge clock) begin
    if (!rstn) begin
      halfTick_r <= 1'b0;
      swPhase_r <= 1'b0;
    end else if (scanTick) begin
      halfTick_r <= ~halfTick_r;
      if (!setup_r[`SETUP_HALVER_BIT] || halfTick_r) begin
        swPhase_r <= ~swPhase_r;
      end
    end
  end
  assign link.switchAOe = link.converterDriveEnable & ~swPhase_r;
  assign link.switchBOe = link.converterDriveEnable & swPhase_r;

  for (genvar i = 0; i < 8; i++) begin : g_filt
    iso_channel_filter u_filt (
      .clock(clock),
      .rstn(rstn),
      .tick(scanTick),
      .sample(sensorIn[i]),
      .length(filtLen_r[i]),
      .level(filtOut[i])
    );
  end

  // data and diagnostic freeze
  always_ff @(posedge clock) begin
    if (!rstn) begin
      syncPrev_r <= 1'b1;
      dataView <= 8'h00;
      diagView <= 8'h00;
    end else begin
      syncPrev_r <= link.sampleFreeze;
      if ((syncPrev_r && !link.sampleFreeze) || (link.sampleFreeze && scanTick)) begin
        dataView <= filtOut;
        diagView <= wireFlag_r & mask_r;
      end
    end
  end

  // sticky fault flags, preset at reset except the check and wire flags; an active cause wins over the clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      gFault_r <= `GFAULT_RESET;
      lFault_r <= `LFAULT_RESET;
      wireFlag_r <= 8'h00;
    end else begin
      gFault_r <= {overcurrent, supplyLost, supplyLow} |
        (gFault_r & {3{~(regRdDone && regRdAddr == `REG_GFAULT)}});
      lFault_r <= {checkEvt, transmitFail} |
        (lFault_r & {2{~(regRdDone && regRdAddr == `REG_LFAULT)}});
      wireFlag_r <= (wireOpen & mask_r & {8{scanTick}}) |
        (wireFlag_r & ~({8{regRdDone && regRdAddr == `REG_DIAG}} & ~wireOpen));
    end
  end
  assign link.faultOe = (|gFault_r) | lFault_r[0];
  assign faultActive = link.faultOe;
  assign link.checkFaultOe = lFault_r[1];

  // writable registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      setup_r <= `SETUP_RESET;
      mask_r <= `MASK_RESET;
      for (int i = 0; i < 8; i++) begin
        filtLen_r[i] <= `FILT_RESET;
      end
    end else if (regWrEn) begin
      if (regWrAddr == `REG_SETUP) begin
        setup_r <= regWrData;
      end
      if (regWrAddr == `REG_MASK) begin
        mask_r <= regWrData;
      end
      if (regWrAddr[6:3] == `REG_FILT_PAGE) begin
        filtLen_r[regWrAddr[2:0]] <= regWrData;
      end
    end
  end

  // parallel port
  assign parActive = !serialMode_r && !link.chipSelN;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      parAddr_r <= 7'h00;
      parDirWr_r <= 1'b0;
      rdActive_r <= 1'b0;
      wrActive_r <= 1'b0;
      parRd_r <= 8'h00;
      parWr_r <= 8'h00;
    end else begin
      if (parActive && link.addrPhase) begin
        parAddr_r <= link.muxedBus[6:0];
        parDirWr_r <= link.muxedBus[7];
      end
      if (parActive && !link.addrPhase && !parDirWr_r && !link.readStrobeN) begin
        if (!rdActive_r) begin
          parRd_r <= readReg(parAddr_r);
        end
        rdActive_r <= 1'b1;
      end else begin
        rdActive_r <= 1'b0;
      end
      if (parActive && !link.addrPhase && parDirWr_r && !link.storeStrobeN) begin
        parWr_r <= link.muxedBus;
        wrActive_r <= 1'b1;
      end else begin
        wrActive_r <= 1'b0;
      end
    end
  end
  assign link.devBus = parRd_r;
  assign link.devBusOe = rdActive_r;

  // serial port
  assign serActive = serialMode_r && !link.chipSelN;
  assign clkRise = serActive && !clkPrev_r && link.shiftClock;
  assign clkFall = serActive && clkPrev_r && !link.shiftClock;
  assign csFall = serialMode_r && csPrev_r && !link.chipSelN;
  assign frameEnd = serialMode_r && !csPrev_r && link.chipSelN;
  assign frameBad = (bitCnt_r != `FRAME_BITS) || (parity_r != ssiLast_r);
  assign checkEvt = frameEnd && frameBad;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      clkPrev_r <= 1'b0;
      csPrev_r <= 1'b1;
      bitCnt_r <= 5'h00;
      rxShift_r <= 16'h0000;
      parity_r <= 1'b0;
      ssiLast_r <= 1'b0;
      txData_r <= 8'h00;
      txDiag_r <= 8'h00;
    end else begin
      clkPrev_r <= link.shiftClock;
      csPrev_r <= link.chipSelN;
      if (csFall) begin
        bitCnt_r <= 5'h00;
        parity_r <= 1'b0;
        txData_r <= dataView;
        txDiag_r <= diagView;
      end else if (clkRise) begin
        rxShift_r <= {rxShift_r[14:0], link.serialInData};
        parity_r <= parity_r ^ link.serialInData;
        ssiLast_r <= link.serialInStatus;
        if (bitCnt_r != 5'h1F) begin
          bitCnt_r <= bitCnt_r + 5'h01;
        end
      end else if (clkFall) begin
        if (bitCnt_r == `ADDR_BITS) begin
          txData_r <= link.linkVariantB0 ? readReg(rxShift_r[6:0]) : dataView;
          txDiag_r <= 8'h00;
        end else begin
          txData_r <= {txData_r[6:0], 1'b0};
          txDiag_r <= {txDiag_r[6:0], 1'b0};
        end
      end
    end
  end
  assign link.serialOutData = txData_r[7];
  assign link.serialOutDiag = txDiag_r[7];

  // one register write and read-effect path for both ports
  always_comb begin
    if (serialMode_r) begin
      regWrEn = frameEnd && !frameBad && rxShift_r[15] && link.linkVariantB1;
      regWrAddr = rxShift_r[14:8];
      regWrData = rxShift_r[7:0];
      regRdDone = frameEnd && !frameBad && !rxShift_r[15];
      regRdAddr = rxShift_r[14:8];
    end else begin
      regWrEn = wrActive_r && link.storeStrobeN;
      regWrAddr = parAddr_r;
      regWrData = parWr_r;
      regRdDone = rdActive_r && link.readStrobeN;
      regRdAddr = parAddr_r;
    end
  end
endmodule
`default_nettype wire

// [hdl/iso_input_host.sv]
// controller end: APB slave registers command parallel or serial transfers
// assumes the device end is joined through iso_link_if
`timescale 1ns/1ps
`default_nettype none
`include "iso_input_cfg.svh"
module iso_input_host import iso_input_pkg::*; (
  iso_link_if.host link, // link pins
  input wire logic clock, // system clock
  input wire logic rstn, // synchronous reset, low active
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr // APB error
);
  host_state_t state_r;
  logic [15:0] cmd_r;
  logic [4:0] config_r;
  logic [7:0] rdata_r;
  logic [7:0] diag_r;
  logic [3:0] cnt_r;
  logic [4:0] bits_r;
  logic [15:0] txS_r;
  logic [15:0] rxS_r;
  logic [7:0] rxD_r;
  logic apbWr;
  logic start;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign apbWr = psel && penable && pwrite;
  assign start = apbWr && paddr == `APB_CMD && state_r == H_IDLE;
  always_comb begin
    case (paddr)
      `APB_CMD: prdata = {16'h0000, cmd_r};
      `APB_STATUS: prdata = {6'h00, link.checkFaultN, link.faultN, diag_r, rdata_r, 7'h00, state_r != H_IDLE};
      `APB_CONFIG: prdata = {27'h0, config_r};
      default: prdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      config_r <= `CONFIG_RESET;
      cmd_r <= 16'h0000;
    end else begin
      if (apbWr && paddr == `APB_CONFIG && state_r == H_IDLE) begin
        config_r <= pwdata[4:0];
      end
      if (start) begin
        cmd_r <= pwdata[15:0];
      end
    end
  end
  assign link.linkTypeSel = config_r[0];
  assign link.linkVariantB0 = config_r[1];
  assign link.linkVariantB1 = config_r[2];
  assign link.sampleFreeze = config_r[3];
  assign link.converterDriveEnable = config_r[4];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= H_IDLE;
      link.chipSelN <= 1'b1;
      link.addrPhase <= 1'b0;
      link.readStrobeN <= 1'b1;
      link.storeStrobeN <= 1'b1;
      link.hostBus <= 8'h00;
      link.hostBusOe <= 1'b0;
      link.shiftClock <= 1'b0;
      link.serialInData <= 1'b0;
      link.serialInStatus <= 1'b0;
      rdata_r <= 8'h00;
      diag_r <= 8'h00;
      cnt_r <= 4'h0;
      bits_r <= 5'h00;
      txS_r <= 16'h0000;
      rxS_r <= 16'h0000;
      rxD_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      case (state_r)
        H_IDLE: begin
          cnt_r <= 4'h0;
          bits_r <= 5'h00;
          if (start) begin
            link.chipSelN <= 1'b0;
            txS_r <= {pwdata[7:0], pwdata[15:8]};
            if (config_r[0]) begin
              link.serialInData <= pwdata[7];
              link.serialInStatus <= ^pwdata[15:0];
              state_r <= H_SER;
            end else begin
              link.addrPhase <= 1'b1;
              link.hostBus <= pwdata[7:0];
              link.hostBusOe <= 1'b1;
              state_r <= H_ADDR;
            end
          end
        end
        H_ADDR: begin
          if (cnt_r == `HOST_PHASE_CYC) begin
            link.addrPhase <= 1'b0;
            link.hostBus <= cmd_r[15:8];
            link.hostBusOe <= cmd_r[7];
            cnt_r <= 4'h0;
            state_r <= H_GAP;
          end
        end
        H_GAP: begin
          link.readStrobeN <= cmd_r[7];
          link.storeStrobeN <= ~cmd_r[7];
          cnt_r <= 4'h0;
          state_r <= H_STROBE;
        end
        H_STROBE: begin
          if (cnt_r == `HOST_PHASE_CYC) begin
            if (!cmd_r[7]) begin
              rdata_r <= link.muxedBus;
            end
            link.readStrobeN <= 1'b1;
            link.storeStrobeN <= 1'b1;
            cnt_r <= 4'h0;
            state_r <= H_HOLD;
          end
        end
        H_SER: begin
          if (cnt_r == `SCLK_HALF_CYC - 4'h1) begin
            cnt_r <= 4'h0;
            if (!link.shiftClock) begin
              link.shiftClock <= 1'b1;
              bits_r <= bits_r + 5'h01;
            end else begin
              link.shiftClock <= 1'b0;
              rxS_r <= {rxS_r[14:0], link.serialOutData};
              // diagnostics ride on the first byte only
              if (bits_r <= `ADDR_BITS) begin
                rxD_r <= {rxD_r[6:0], link.serialOutDiag};
              end
              txS_r <= {txS_r[14:0], 1'b0};
              link.serialInData <= txS_r[14];
              if (bits_r == `FRAME_BITS) begin
                state_r <= H_HOLD;
              end
            end
          end
        end
        H_HOLD: begin
          link.hostBusOe <= 1'b0;
          if (cnt_r == `HOST_PHASE_CYC) begin
            link.chipSelN <= 1'b1;
            if (config_r[0]) begin
              rdata_r <= rxS_r[7:0];
              diag_r <= rxD_r;
            end
            state_r <= H_IDLE;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [verif/isolated_input_host_interface_assertions.sv]
// pin-level checker for the link between controller and device ends
// assumes it sits beside the interface and sees the device end's reset
`timescale 1ns/1ps
`default_nettype none
module isolated_input_host_interface_assertions #(
  parameter int SCAN_DIV = 40
) (
  input wire logic clock, // system clock
  input wire logic rstn, // device end reset, low active
  input wire logic chipSelN, // chip select, low active
  input wire logic converterDriveEnable, // converter drive enable
  input wire logic addrPhase, // address phase strobe
  input wire logic readStrobeN, // read strobe, low active
  input wire logic storeStrobeN, // store strobe, low active
  input wire logic hostBusOe, // host drives bus
  input wire logic devBusOe, // device drives bus
  input wire logic shiftClock, // serial shift clock
  input wire logic serialOutData, // serial data out
  input wire logic serialOutDiag, // serial diagnostics out
  input wire logic checkFaultOe, // check fault pulled low
  input wire logic switchAOe, // switch a enable
  input wire logic switchBOe // switch b enable
);
  localparam int TOGGLE_SPAN = 2 * SCAN_DIV + 2;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence readHeld;
    !chipSelN && !readStrobeN ##1 !readStrobeN;
  endsequence
  sequence switchAOn;
    converterDriveEnable && switchAOe;
  endsequence
  AST_SWITCH_EXCL: assert property (!(switchAOe && switchBOe) && ((switchAOe || switchBOe) -> converterDriveEnable))
    else $error("switch outputs overlap or run without enable");
  AST_SWITCH_TOGGLE: assert property (switchAOn |-> ##[1:TOGGLE_SPAN] (switchBOe || !converterDriveEnable))
    else $error("switch phase did not toggle in time");
  AST_ADDR_DRIVE: assert property (addrPhase |-> !chipSelN && hostBusOe && !devBusOe)
    else $error("address phase without select or host drive");
  AST_STROBE_EXCL: assert property (!(!readStrobeN && !storeStrobeN))
    else $error("read and store strobes overlap");
  AST_STROBE_SEL: assert property ((!readStrobeN || !storeStrobeN) |-> !chipSelN && !addrPhase)
    else $error("strobe outside a selected data phase");
  AST_READ_DRIVE: assert property (readHeld |-> devBusOe)
    else $error("device not driving bus during read strobe");
  AST_STORE_BUS: assert property (!storeStrobeN |-> hostBusOe && !devBusOe)
    else $error("bus not driven by host during store");
  AST_CS_RELEASE: assert property (chipSelN && $past(chipSelN) |-> !devBusOe)
    else $error("device drives bus while deselected");
  AST_SER_EDGE: assert property ($changed(serialOutData) || $changed(serialOutDiag) |-> !shiftClock)
    else $error("serial outputs changed while shift clock high");
  AST_CHECK_FRAME: assert property ($rose(checkFaultOe) |-> chipSelN)
    else $error("check fault raised inside a frame");
  cover property (readHeld);
endmodule
`default_nettype wire

// [verif/tb_isolated_input_host_interface.sv]
// self-checking bench: APB controller end joined to the device end
// assumes the config header offsets and a 50 ns clock
`timescale 1ns/1ps
`default_nettype none
`include "iso_input_cfg.svh"
module tb_isolated_input_host_interface import iso_input_pkg::*;;
  localparam int SCAN = 4;
  typedef struct packed {logic dir; logic [6:0] addr; logic [7:0] data; logic flt;} row_t;
  logic clock = 1'h0;
  logic hostRstn, devRstn, psel, penable, pwrite, pready, swSeen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, status;
  logic [7:0] sensorIn, wireOpen, dataView, diagView, rd;
  logic supplyLow, supplyLost, transmitFail, overcurrent, faultActive;
  int numErrors = 0;
  int samplesChecked = 0;
  int n;
  row_t rows [0:10] = '{'{1'h0, 7'h03, 8'h07, 1'h1}, '{1'h0, 7'h04, 8'h01, 1'h0}, '{1'h0, 7'h03, 8'h00, 1'h0},
    '{1'h0, 7'h05, 8'hFF, 1'h0}, '{1'h1, 7'h02, 8'h01, 1'h0}, '{1'h0, 7'h02, 8'h01, 1'h0},
    '{1'h1, 7'h0F, 8'h06, 1'h0}, '{1'h0, 7'h0F, 8'h06, 1'h0}, '{1'h0, 7'h08, 8'h03, 1'h0},
    '{1'h0, 7'h07, 8'h00, 1'h0}, '{1'h1, 7'h00, 8'h3C, 1'h0}};
  iso_link_if link();
  iso_input_host i_iso_input_host (.link(link), .clock(clock), .rstn(hostRstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr());
  iso_input_device #(.SCAN_DIV(SCAN)) i_iso_input_device (.link(link), .clock(clock), .rstn(devRstn),
    .sensorIn(sensorIn), .wireOpen(wireOpen), .supplyLow(supplyLow), .supplyLost(supplyLost),
    .transmitFail(transmitFail), .overcurrent(overcurrent), .dataView(dataView), .diagView(diagView),
    .faultActive(faultActive));
  isolated_input_host_interface_assertions #(.SCAN_DIV(SCAN)) i_isolated_input_host_interface_assertions (
    .clock(clock), .rstn(devRstn), .chipSelN(link.chipSelN), .converterDriveEnable(link.converterDriveEnable),
    .addrPhase(link.addrPhase), .readStrobeN(link.readStrobeN), .storeStrobeN(link.storeStrobeN),
    .hostBusOe(link.hostBusOe), .devBusOe(link.devBusOe), .shiftClock(link.shiftClock),
    .serialOutData(link.serialOutData), .serialOutDiag(link.serialOutDiag), .checkFaultOe(link.checkFaultOe),
    .switchAOe(link.switchAOe), .switchBOe(link.switchBOe));
  always #25 clock = ~clock;
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      numErrors++;
    end
  endtask
  task automatic summarize;
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one APB transfer; setup starts at the next edge so back-to-back calls never collide
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cmd(input logic dir, input logic [6:0] a, input logic [7:0] d);
    int k;
    apb(1'h1, `APB_CMD, {16'h0000, d, dir, a}, status);
    k = 0;
    do begin
      apb(1'h0, `APB_STATUS, 32'h00000000, status);
      k++;
    end while (status[0] !== 1'h0 && k < 400);
    if (status[0] !== 1'h0) begin
      $display("[ERR] busy expected 0 seen %b", status[0]);
      numErrors++;
    end
    rd = status[15:8];
  endtask
  task automatic cfg(input logic [4:0] v);
    apb(1'h1, `APB_CONFIG, {27'h0000000, v}, status);
  endtask
  // the device reads the link type strap only when leaving reset
  task automatic devReset;
    @(posedge clock);
    devRstn <= 1'h0;
    repeat (2) @(posedge clock);
    devRstn <= 1'h1;
  endtask
  // cycles from one rise of switch a to the next
  task automatic period(output int c);
    c = 0;
    do @(posedge clock); while (link.switchAOe);
    do @(posedge clock); while (!link.switchAOe);
    do begin
      @(posedge clock);
      c++;
    end while (link.switchAOe);
    do begin
      @(posedge clock);
      c++;
    end while (!link.switchAOe);
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    numErrors++;
    summarize();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {hostRstn, devRstn, supplyLow, supplyLost, transmitFail, overcurrent} = '0;
    sensorIn = 8'hA5;
    wireOpen = 8'h00;
    repeat (2) @(posedge clock);
    hostRstn <= 1'h1;
    devRstn <= 1'h1;
    @(posedge clock);
    check("fault after reset", 8'h01, {7'h00, faultActive});
    check("check fault pin", 8'h01, {7'h00, link.checkFaultN});
    cfg(5'h18);
    devReset();
    foreach (rows[i]) begin
      cmd(rows[i].dir, rows[i].addr, rows[i].data);
      if (!rows[i].dir) check("parallel read", rows[i].data, rd);
      check("fault output", {7'h00, rows[i].flt}, {7'h00, faultActive});
    end
    period(n);
    check("halved switch period", 8'(4 * SCAN), 8'(n));
    cmd(1'h1, 7'h02, 8'h00);
    period(n);
    check("switch period", 8'(2 * SCAN), 8'(n));
    cfg(5'h08);
    swSeen = 1'h0;
    repeat (20) begin
      @(posedge clock);
      swSeen = swSeen | link.switchAOe | link.switchBOe;
    end
    check("switches idle", 8'h00, {7'h00, swSeen});
    for (int i = 0; i < 4; i++) begin
      {overcurrent, transmitFail, supplyLost, supplyLow} <= 4'h1 << i;
      repeat (8) @(posedge clock);
      check("fault raised", 8'h01, {7'h00, faultActive});
      check("fault pin", 8'h00, {7'h00, link.faultN});
      {overcurrent, transmitFail, supplyLost, supplyLow} <= 4'h0;
      cmd(1'h0, 7'h03, 8'h00);
      cmd(1'h0, 7'h04, 8'h00);
      check("fault cleared", 8'h00, {7'h00, faultActive});
    end
    check("data view", 8'hA5, dataView);
    cmd(1'h0, 7'h00, 8'h00);
    check("data register", 8'hA5, rd);
    sensorIn <= 8'h5A;
    repeat (6) @(posedge clock);
    check("filter hold", 8'hA5, dataView);
    repeat (40) @(posedge clock);
    check("filter change", 8'h5A, dataView);
    cfg(5'h00);
    sensorIn <= 8'hC3;
    repeat (60) @(posedge clock);
    check("frozen view", 8'h5A, dataView);
    cfg(5'h08);
    repeat (40) @(posedge clock);
    check("running view", 8'hC3, dataView);
    cfg(5'h0F);
    devReset();
    cmd(1'h1, 7'h08, 8'h07);
    cmd(1'h0, 7'h08, 8'h00);
    check("serial readback", 8'h07, rd);
    wireOpen <= 8'h81;
    cfg(5'h0B);
    cmd(1'h1, 7'h08, 8'h09);
    cmd(1'h0, 7'h08, 8'h00);
    check("serial write refused", 8'h07, rd);
    cfg(5'h09);
    cmd(1'h0, 7'h03, 8'h00);
    check("serial sensor data", 8'hC3, rd);
    check("serial diag", 8'h81, status[23:16]);
    wireOpen <= 8'h00;
    cmd(1'h0, 7'h04, 8'h00);
    check("serial fault cleared", 8'h00, {7'h00, faultActive});
    check("sticky diag", 8'h81, status[23:16]);
    cmd(1'h0, 7'h01, 8'h00);
    repeat (10) @(posedge clock);
    cmd(1'h0, 7'h04, 8'h00);
    check("diag cleared", 8'h00, status[23:16]);
    check("check fault pin", 8'h01, {7'h00, link.checkFaultN});
    // host reset mid-frame leaves the device a cut frame
    apb(1'h1, `APB_CMD, 32'h0000_0003, status);
    repeat (40) @(posedge clock);
    hostRstn <= 1'h0;
    repeat (2) @(posedge clock);
    hostRstn <= 1'h1;
    repeat (3) @(posedge clock);
    check("cut frame fault pin", 8'h00, {7'h00, link.checkFaultN});
    cmd(1'h0, 7'h04, 8'h00);
    check("check fault cleared", 8'h01, {7'h00, link.checkFaultN});
    summarize();
  end
endmodule
`default_nettype wire
